// ### hdl/bmfc_top.sv
// Buck mode and fault control: trims, mode selection, pulse timing, fault flags and power-good routing.
//
// Overview of operation
// R1 - Minimum on-time codes give 40/60/80/100 ns
// R2 - Software should program minimum on-time code 01
// R3 - Ratio above six halves the switching frequency
// R4 - Pin select zero: sync input, register mode
// R5 - Mode 00 is PFM, 11 is PWM
// R6 - Pin select one: low PWM, high PFM
// R7 - Software leaves register mode alone in pin mode
// R8 - Pulse on-time codes give 160/320/640/800 ns
// R9 - Software should program pulse on-time code 10
// R10 - Startup ramps over selected soft-start duration
// R11 - Four-step current limit, recovers when cleared
// R12 - Slope, transconductance, resistor compensation selections
// R13 - Feedback comparators flag under and overvoltage
// R14 - Overvoltage drives power-good outputs when routed
// R15 - Undervoltage drives power-good outputs when routed
// R16 - Faults latch flags; write one clears
// R17 - Live status bits follow present faults
// R18 - Fault present during clear keeps flag
`timescale 1ns/1ps
`default_nettype none
module bmfc_top
	import bmfc_pkg::*;
#(
	parameter int SS_BASE_CYCLES = 4000 // Soft-start cycles per step of the selection
)
(
	// Clock and reset
	input  wire logic        mclk_i,
	input  wire logic        reset_i,
	// Register port
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	// Board pin and analog inputs
	input  wire logic        mode_sync_pin_i,
	input  wire logic        undervolt_cmp_i,
	input  wire logic        overvolt_cmp_i,
	input  wire logic [7:0]  vin_vout_ratio_i,
	input  wire logic        overcurrent_i,
	input  wire logic        enable_i,
	input  wire logic        cycle_start_i,
	// Converter controls
	output logic             pwm_mode_o,
	output logic             sync_in_o,
	output logic             half_freq_o,
	output logic             hs_min_on_o,
	output logic             pfm_on_o,
	output logic             hs_gate_allow_o,
	output logic             softstart_busy_o,
	output logic      [1:0]  current_limit_sel_o,
	output logic      [1:0]  slope_comp_sel_o,
	output logic      [1:0]  transconductance_sel_o,
	output logic      [2:0]  comp_resistor_sel_o,
	// Power good and interrupt
	output logic             power_good_out1_o,
	output logic             power_good_out2_o,
	output logic             irq_o
);
	// Trim image fields
	logic [1:0]  min_on_time_sel_r;      // Minimum high-side on-time code
	logic [1:0]  pulse_on_time_sel_r;    // Pulse-frequency on-time code
	logic [1:0]  softstart_sel_r;        // Soft-start length code
	logic [1:0]  current_limit_sel_r;    // Current limit code
	logic [1:0]  slope_comp_sel_r;       // Slope compensation code
	logic [1:0]  transconductance_sel_r; // Amplifier transconductance code
	logic [2:0]  comp_resistor_sel_r;    // Compensation resistor code
	logic [1:0]  default_operating_mode_r; // Mode loaded into the mode field at reset
	// Mode and routing
	logic        pin_function_sel_r;     // 0 sync input, 1 mode input
	logic [1:0]  reg_operating_mode_r;   // Software mode field
	logic        overvolt_to_good1_en_r;
	logic        overvolt_to_good2_en_r;
	logic        undervolt_to_good1_en_r;
	logic        undervolt_to_good2_en_r;
	// Fault flags and mask
	logic        undervolt_latched_flag_r;
	logic        overvolt_latched_flag_r;
	logic [1:0]  irq_mask_r;
	// Soft-start sequencer
	bmfc_state_e ss_state_r;
	logic [15:0] ss_cnt_r;
	logic        mode_pin_r;             // Pin level seen last cycle
	logic        uv_live_r;              // Registered live undervoltage
	logic        ov_live_r;              // Registered live overvoltage

	// Cycle count for a time in ns, rounded up, at least one
	function automatic logic [5:0] ns_to_cycles(input int ns);
		int c;
		c = (ns + BMFC_CLK_NS - 1) / BMFC_CLK_NS;
		if (c < 1) c = 1;
		return c[5:0];
	endfunction

	// Write strobes per register
	wire         wr_otp   = wr_i && (addr_i == BMFC_OTP_ADDR);
	wire         wr_mode  = wr_i && (addr_i == BMFC_MODE_ADDR);
	wire         wr_route = wr_i && (addr_i == BMFC_ROUTE_ADDR);
	wire         wr_flag  = wr_i && (addr_i == BMFC_FLAG_ADDR);
	wire         wr_mask  = wr_i && (addr_i == BMFC_MASK_ADDR);

	// Mode selection: pin in mode-input use, else register field [R4] [R6]
	wire         reg_is_pwm  = (reg_operating_mode_r == BMFC_MODE_PWM); // [R5]
	wire         pwm_sel     = pin_function_sel_r ? ~mode_pin_r : reg_is_pwm;
	wire         half_sel    = (vin_vout_ratio_i > BMFC_RATIO_LIMIT); // [R3]

	// Timer loads from the lookup of the selected code [R1] [R8]
	wire  [5:0]  min_on_cyc  = ns_to_cycles(BMFC_MINTON_NS[min_on_time_sel_r]);
	wire  [5:0]  pfm_on_cyc  = ns_to_cycles(BMFC_PFMTON_NS[pulse_on_time_sel_r]);
	wire         min_on_w;
	wire         pfm_on_w;

	// Fault flag next values; a live fault beats the clear [R16] [R18]
	wire         uv_clr      = wr_flag && wdata_i[BMFC_UV_BIT];
	wire         ov_clr      = wr_flag && wdata_i[BMFC_OV_BIT];
	wire         uv_flag_nxt = uv_live_r | (undervolt_latched_flag_r & ~uv_clr);
	wire         ov_flag_nxt = ov_live_r | (overvolt_latched_flag_r & ~ov_clr);
	// Power-good drive from routed faults [R14] [R15]
	wire         good1_nxt   = (ov_live_r & overvolt_to_good1_en_r) | (uv_live_r & undervolt_to_good1_en_r);
	wire         good2_nxt   = (ov_live_r & overvolt_to_good2_en_r) | (uv_live_r & undervolt_to_good2_en_r);
	wire  [1:0]  flags_w     = {overvolt_latched_flag_r, undervolt_latched_flag_r};
	wire         irq_nxt     = |({ov_flag_nxt, uv_flag_nxt} & irq_mask_r);

	// Soft-start length grows with the selection code [R10]
	wire  [15:0] ss_len      = 16'((32'(softstart_sel_r) + 32'd1) * SS_BASE_CYCLES);

	// Read mux
	wire  [31:0] otp_rd  = {16'h0000, default_operating_mode_r[0], comp_resistor_sel_r, transconductance_sel_r,
	                        slope_comp_sel_r, current_limit_sel_r, softstart_sel_r, pulse_on_time_sel_r,
	                        min_on_time_sel_r} | {15'h0000, default_operating_mode_r[1], 16'h0000};
	wire  [31:0] rd_data = (addr_i == BMFC_OTP_ADDR)   ? otp_rd :
	                       (addr_i == BMFC_MODE_ADDR)  ? {29'h0, pin_function_sel_r, reg_operating_mode_r} :
	                       (addr_i == BMFC_ROUTE_ADDR) ? {28'h0, undervolt_to_good2_en_r, undervolt_to_good1_en_r,
	                                                      overvolt_to_good2_en_r, overvolt_to_good1_en_r} :
	                       (addr_i == BMFC_FLAG_ADDR)  ? {30'h0, flags_w} :
	                       (addr_i == BMFC_MASK_ADDR)  ? {30'h0, irq_mask_r} :
	                       (addr_i == BMFC_STAT_ADDR)  ? {24'h0, ss_state_r == BMFC_RUN, half_sel, pwm_sel,
	                                                      overcurrent_i, 2'h0, ov_live_r, uv_live_r} :
	                       32'h0000_0000; // Unmapped reads as zero

	// Minimum on-time one-shot
	bmfc_pulse_timer u_min_on (
		.mclk_i   (mclk_i),
		.reset_i  (reset_i),
		.start_i  (cycle_start_i),
		.cycles_i (min_on_cyc),
		.on_o     (min_on_w)
	);

	// Pulse-frequency on-time one-shot, fired only in that mode
	bmfc_pulse_timer u_pfm_on (
		.mclk_i   (mclk_i),
		.reset_i  (reset_i),
		.start_i  (cycle_start_i && !pwm_sel),
		.cycles_i (pfm_on_cyc),
		.on_o     (pfm_on_w)
	);

	// Trim image; stands for the programmed fuses, writable for bring-up
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			min_on_time_sel_r        <= BMFC_MINTON_RST;
			pulse_on_time_sel_r      <= BMFC_PFMTON_RST;
			softstart_sel_r          <= BMFC_SS_RST;
			current_limit_sel_r      <= BMFC_ILIM_RST;
			slope_comp_sel_r         <= BMFC_SLOPE_RST;
			transconductance_sel_r   <= BMFC_GM_RST;
			comp_resistor_sel_r      <= BMFC_RCOMP_RST;
			default_operating_mode_r <= BMFC_DEFMODE_RST;
		end else if (wr_otp) begin
			min_on_time_sel_r        <= wdata_i[BMFC_MINTON_LSB +: 2];
			pulse_on_time_sel_r      <= wdata_i[BMFC_PFMTON_LSB +: 2];
			softstart_sel_r          <= wdata_i[BMFC_SS_LSB +: 2];
			current_limit_sel_r      <= wdata_i[BMFC_ILIM_LSB +: 2]; // [R11]
			slope_comp_sel_r         <= wdata_i[BMFC_SLOPE_LSB +: 2]; // [R12]
			transconductance_sel_r   <= wdata_i[BMFC_GM_LSB +: 2];
			comp_resistor_sel_r      <= wdata_i[BMFC_RCOMP_LSB +: 3];
			default_operating_mode_r <= wdata_i[BMFC_DEFMODE_LSB +: 2];
		end
	end

	// Mode field: reset takes the fuse default; reserved codes are not filtered [R4]
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			reg_operating_mode_r <= BMFC_DEFMODE_RST;
			pin_function_sel_r   <= BMFC_PINSEL_RST;
		end else if (wr_mode) begin
			reg_operating_mode_r <= wdata_i[1:0];
			pin_function_sel_r   <= wdata_i[2];
		end
	end

	// Routing and mask
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			{undervolt_to_good2_en_r, undervolt_to_good1_en_r,
			 overvolt_to_good2_en_r, overvolt_to_good1_en_r} <= BMFC_ROUTE_RST;
			irq_mask_r <= 2'h0;
		end else begin
			if (wr_route) begin
				{undervolt_to_good2_en_r, undervolt_to_good1_en_r,
				 overvolt_to_good2_en_r, overvolt_to_good1_en_r} <= wdata_i[3:0];
			end
			if (wr_mask) begin
				irq_mask_r <= wdata_i[1:0];
			end
		end
	end

	// Comparator sampling and fault flags; live bits never latch [R13] [R17]
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			uv_live_r                <= 1'b0;
			ov_live_r                <= 1'b0;
			mode_pin_r               <= 1'b0;
			undervolt_latched_flag_r <= 1'b0;
			overvolt_latched_flag_r  <= 1'b0;
		end else begin
			uv_live_r                <= undervolt_cmp_i;
			ov_live_r                <= overvolt_cmp_i;
			mode_pin_r               <= mode_sync_pin_i;
			undervolt_latched_flag_r <= uv_flag_nxt; // [R16]
			overvolt_latched_flag_r  <= ov_flag_nxt;
		end
	end

	// Soft-start sequencer: idle until enabled, ramp for the chosen length, then run [R10]
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			ss_state_r <= BMFC_IDLE;
			ss_cnt_r   <= 16'h0000;
		end else if (!enable_i) begin
			ss_state_r <= BMFC_IDLE;
			ss_cnt_r   <= 16'h0000;
		end else begin
			case (ss_state_r)
				BMFC_IDLE: begin
					ss_state_r <= BMFC_RAMP;
					ss_cnt_r   <= ss_len;
				end
				BMFC_RAMP: begin
					if (ss_cnt_r <= 16'h0001) begin
						ss_state_r <= BMFC_RUN;
					end
					ss_cnt_r <= ss_cnt_r - 16'h0001;
				end
				default: begin
					ss_state_r <= BMFC_RUN;
				end
			endcase
		end
	end

	// Output registers
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			rdata_o                <= 32'h0000_0000;
			pwm_mode_o             <= 1'b0;
			sync_in_o              <= 1'b0;
			half_freq_o            <= 1'b0;
			hs_min_on_o            <= 1'b0;
			pfm_on_o               <= 1'b0;
			hs_gate_allow_o        <= 1'b0;
			softstart_busy_o       <= 1'b0;
			current_limit_sel_o    <= BMFC_ILIM_RST;
			slope_comp_sel_o       <= BMFC_SLOPE_RST;
			transconductance_sel_o <= BMFC_GM_RST;
			comp_resistor_sel_o    <= BMFC_RCOMP_RST;
			power_good_out1_o      <= 1'b0;
			power_good_out2_o      <= 1'b0;
			irq_o                  <= 1'b0;
		end else begin
			rdata_o                <= rd_i ? rd_data : 32'h0000_0000;
			pwm_mode_o             <= pwm_sel; // [R5] [R6]
			sync_in_o              <= !pin_function_sel_r && mode_pin_r; // [R4]
			half_freq_o            <= half_sel; // [R3]
			hs_min_on_o            <= min_on_w; // [R1]
			pfm_on_o               <= pfm_on_w; // [R8]
			// Overcurrent cuts the gate for every cycle it stands; the cycle after it drops resumes [R11]
			hs_gate_allow_o        <= (ss_state_r != BMFC_IDLE) && !overcurrent_i;
			softstart_busy_o       <= (ss_state_r == BMFC_RAMP);
			current_limit_sel_o    <= current_limit_sel_r;
			slope_comp_sel_o       <= slope_comp_sel_r; // [R12]
			transconductance_sel_o <= transconductance_sel_r;
			comp_resistor_sel_o    <= comp_resistor_sel_r;
			power_good_out1_o      <= good1_nxt; // [R14] [R15]
			power_good_out2_o      <= good2_nxt;
			irq_o                  <= irq_nxt;
		end
	end

	// Live fault sets its flag one cycle later, even against a clear
	flag_set_a: assert property (@(posedge mclk_i) disable iff (reset_i)
		uv_live_r |=> undervolt_latched_flag_r) else $error("Undervoltage flag not set"); // [R16]
	// Clear with no fault drops the flag
	flag_clr_a: assert property (@(posedge mclk_i) disable iff (reset_i)
		(ov_clr && !ov_live_r) |=> !overvolt_latched_flag_r) else $error("Overvoltage flag not cleared"); // [R16]
	// Clear racing a fault keeps the flag
	clear_race_a: assert property (@(posedge mclk_i) disable iff (reset_i)
		(ov_clr && ov_live_r) |=> overvolt_latched_flag_r) else $error("Clear beat a live fault"); // [R18]
	// Routed overvoltage drives good output one
	good1_ov_a: assert property (@(posedge mclk_i) disable iff (reset_i)
		(overvolt_cmp_i && overvolt_to_good1_en_r && !wr_route) ##1 !wr_route |=> power_good_out1_o)
		else $error("Good output one missed overvoltage"); // [R14]
	// Unrouted faults leave good output two low
	good2_quiet_a: assert property (@(posedge mclk_i) disable iff (reset_i)
		(!undervolt_to_good2_en_r && !overvolt_to_good2_en_r && !wr_route) |=> !power_good_out2_o)
		else $error("Good output two without routing"); // [R15]
	// Pin mode: low pin gives PWM two cycles on
	pin_mode_a: assert property (@(posedge mclk_i) disable iff (reset_i)
		(pin_function_sel_r && !mode_sync_pin_i && !wr_mode) ##1 pin_function_sel_r |=> pwm_mode_o)
		else $error("Pin low did not select PWM"); // [R6]
	// Register mode: code 00 gives pulse-frequency mode
	reg_mode_a: assert property (@(posedge mclk_i) disable iff (reset_i)
		(!pin_function_sel_r && reg_operating_mode_r == BMFC_MODE_PFM) |=> !pwm_mode_o)
		else $error("Register PFM ignored"); // [R4] [R5]
	// Ratio above limit halves frequency next cycle
	half_freq_a: assert property (@(posedge mclk_i) disable iff (reset_i)
		(vin_vout_ratio_i > BMFC_RATIO_LIMIT) |=> half_freq_o) else $error("Half frequency missed"); // [R3]
	// Minimum on-time code 00 lasts two cycles
	sequence min_pulse_s;
		hs_min_on_o [*2] ##1 !hs_min_on_o;
	endsequence
	min_on_a: assert property (@(posedge mclk_i) disable iff (reset_i)
		(cycle_start_i && min_on_time_sel_r == 2'h0) ##1 !cycle_start_i ##1 !cycle_start_i |-> ##0 min_pulse_s)
		else $error("Minimum on-time length wrong"); // [R1]
	// Live status tracks comparator without latching
	live_stat_a: assert property (@(posedge mclk_i) disable iff (reset_i)
		!undervolt_cmp_i |=> !uv_live_r) else $error("Live status latched"); // [R17]
	// Overcurrent cuts the gate the next cycle
	oc_cut_a: assert property (@(posedge mclk_i) disable iff (reset_i)
		overcurrent_i |=> !hs_gate_allow_o) else $error("Overcurrent not limited"); // [R11]
	// Sync use passes a high pin level on two cycles later
	sync_pass_a: assert property (@(posedge mclk_i) disable iff (reset_i)
		mode_sync_pin_i ##1 !pin_function_sel_r |=> sync_in_o)
		else $error("Sync level not passed on"); // [R4]
	// PWM with an idle window never opens a pulse-frequency window
	pfm_quiet_a: assert property (@(posedge mclk_i) disable iff (reset_i)
		(pwm_sel && !pfm_on_w) |=> ##1 !pfm_on_o)
		else $error("Pulse window opened in PWM"); // [R5] [R8]
endmodule
`default_nettype wire

// ### hdl/bmfc_pkg.sv
// Package for the buck mode and fault control block: offsets, fields, reset values, encodings, timing counts.
`default_nettype none
package bmfc_pkg;
	// Register byte offsets
	localparam logic [7:0] BMFC_OTP_ADDR    = 8'h00; // Trimmed selections (one-time programmed image)
	localparam logic [7:0] BMFC_MODE_ADDR   = 8'h04; // Operating mode and pin function
	localparam logic [7:0] BMFC_ROUTE_ADDR  = 8'h08; // Fault to power-good routing
	localparam logic [7:0] BMFC_FLAG_ADDR   = 8'h0c; // Latched fault flags, write one to clear
	localparam logic [7:0] BMFC_MASK_ADDR   = 8'h10; // Interrupt mask
	localparam logic [7:0] BMFC_STAT_ADDR   = 8'h14; // Live status and derived values
	// Field positions in the trim register
	localparam int BMFC_MINTON_LSB = 0;
	localparam int BMFC_PFMTON_LSB = 2;
	localparam int BMFC_SS_LSB     = 4;
	localparam int BMFC_ILIM_LSB   = 6;
	localparam int BMFC_SLOPE_LSB  = 8;
	localparam int BMFC_GM_LSB     = 10;
	localparam int BMFC_RCOMP_LSB  = 12;
	localparam int BMFC_DEFMODE_LSB = 15;
	// Field positions in the flag, mask and status registers
	localparam int BMFC_UV_BIT = 0;
	localparam int BMFC_OV_BIT = 1;
	// Reset values of the trim image, pin function select and routing
	localparam logic [1:0] BMFC_MINTON_RST  = 2'h1;
	localparam logic [1:0] BMFC_PFMTON_RST  = 2'h2;
	localparam logic [1:0] BMFC_SS_RST      = 2'h0;
	localparam logic [1:0] BMFC_ILIM_RST    = 2'h0;
	localparam logic [1:0] BMFC_SLOPE_RST   = 2'h2;
	localparam logic [1:0] BMFC_GM_RST      = 2'h2;
	localparam logic [2:0] BMFC_RCOMP_RST   = 3'h0;
	localparam logic [1:0] BMFC_DEFMODE_RST = 2'h3;
	localparam logic       BMFC_PINSEL_RST  = 1'b0;
	localparam logic [3:0] BMFC_ROUTE_RST   = 4'hf;
	// Operating mode codes
	localparam logic [1:0] BMFC_MODE_PFM = 2'h0;
	localparam logic [1:0] BMFC_MODE_PWM = 2'h3;
	// Ratio limit above which switching halves
	localparam logic [7:0] BMFC_RATIO_LIMIT = 8'h06;
	// Timing in ns and clock period
	localparam int BMFC_CLK_NS = 25;
	localparam int BMFC_MINTON_NS [4] = '{40, 60, 80, 100};
	localparam int BMFC_PFMTON_NS [4] = '{160, 320, 640, 800};
	// Analog units, scaled by ten for slope
	localparam int BMFC_SLOPE_X10 [4] = '{450, 675, 900, 1125};
	localparam int BMFC_GM_US     [4] = '{14, 21, 28, 35};
	localparam int BMFC_RCOMP_STEP_KOHM = 150;
	typedef enum logic [1:0] {BMFC_IDLE, BMFC_RAMP, BMFC_RUN} bmfc_state_e;
endpackage
`default_nettype wire

// ### hdl/bmfc_pulse_timer.sv
// One-shot on-time timer: holds its output for a loaded number of clock cycles.
`timescale 1ns/1ps
`default_nettype none
module bmfc_pulse_timer
	import bmfc_pkg::*;
(
	// Clock and reset
	input  wire logic       mclk_i,
	input  wire logic       reset_i,
	// Control
	input  wire logic       start_i,
	input  wire logic [5:0] cycles_i,
	// Pulse
	output logic            on_o
);
	logic [5:0] cnt_r; // Cycles left in the pulse

	// Load on start, count down to zero; output is the count being nonzero
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			cnt_r <= 6'h00;
			on_o  <= 1'b0;
		end else if (start_i) begin
			cnt_r <= cycles_i;
			on_o  <= (cycles_i != 6'h00);
		end else if (cnt_r != 6'h00) begin
			cnt_r <= cnt_r - 6'h01;
			on_o  <= (cnt_r > 6'h01);
		end else begin
			on_o  <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ### bench/bmfc_far_model.sv
// Far-side model: board mode pin and feedback comparators, registered onto the pins.
`timescale 1ns/1ps
`default_nettype none
module bmfc_far_model (
	// Clock
	input  wire logic mclk_i,
	// Requests from the bench
	input  wire logic pin_req_i,
	input  wire logic uv_req_i,
	input  wire logic ov_req_i,
	// Board-side levels
	output logic      mode_sync_pin_o = 1'b0,
	output logic      undervolt_cmp_o = 1'b0,
	output logic      overvolt_cmp_o  = 1'b0
);
	// Levels move just after the edge, so the block always samples a settled comparator
	always @(posedge mclk_i) begin
		mode_sync_pin_o <= pin_req_i; // Mode level: low asks for PWM, high for PFM
		undervolt_cmp_o <= uv_req_i;  // Feedback below the lower threshold
		overvolt_cmp_o  <= ov_req_i;  // Feedback above the upper threshold
	end
endmodule
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the buck mode and fault control block.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import bmfc_pkg::*;
	localparam int SS_BASE = 4; // Short soft-start step keeps the run brief
	logic        mclk_i = 1'b0;         // 40 MHz clock
	logic        reset_i = 1'b1;        // Synchronous reset
	logic [7:0]  addr_i = 8'h00;        // Register address
	logic [31:0] wdata_i = 32'h0;       // Write data
	logic        wr_i = 1'b0;           // Write strobe
	logic        rd_i = 1'b0;           // Read strobe
	logic [31:0] rdata_o;               // Read data
	logic        pin_req = 1'b0;        // Wanted mode pin level
	logic        uv_req = 1'b0;         // Wanted undervoltage level
	logic        ov_req = 1'b0;         // Wanted overvoltage level
	logic [7:0]  vin_vout_ratio_i = 8'h01;
	logic        overcurrent_i = 1'b0;
	logic        enable_i = 1'b0;
	logic        cycle_start_i = 1'b0;
	wire         pin_w, uv_w, ov_w;     // Pins driven by the far-side model
	logic        pwm, sync, half, hs_on, pfm_on, gate, busy, pg1, pg2, irq;
	logic [1:0]  ilim, slope, gm;
	logic [2:0]  rcomp;
	int          mismatches = 0;
	int          samples_checked = 0;
	int          seed = 91855;          // Fixed seed, repeatable run
	// Free-running clock
	always #12.5 mclk_i = ~mclk_i;
	bmfc_far_model u_bmfc_far_model (.mclk_i(mclk_i), .pin_req_i(pin_req), .uv_req_i(uv_req),
		.ov_req_i(ov_req), .mode_sync_pin_o(pin_w), .undervolt_cmp_o(uv_w), .overvolt_cmp_o(ov_w));
	bmfc_top #(.SS_BASE_CYCLES(SS_BASE)) u_bmfc_top (.mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .mode_sync_pin_i(pin_w),
		.undervolt_cmp_i(uv_w), .overvolt_cmp_i(ov_w), .vin_vout_ratio_i(vin_vout_ratio_i),
		.overcurrent_i(overcurrent_i), .enable_i(enable_i), .cycle_start_i(cycle_start_i),
		.pwm_mode_o(pwm), .sync_in_o(sync), .half_freq_o(half), .hs_min_on_o(hs_on), .pfm_on_o(pfm_on),
		.hs_gate_allow_o(gate), .softstart_busy_o(busy), .current_limit_sel_o(ilim),
		.slope_comp_sel_o(slope), .transconductance_sel_o(gm), .comp_resistor_sel_o(rcomp),
		.power_good_out1_o(pg1), .power_good_out2_o(pg2), .irq_o(irq));
	// Compare and count; four-state equality so an unknown never matches
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One-cycle write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		wr_i    <= 1'b1;
		addr_i  <= a;
		wdata_i <= d;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	// One-cycle read; data stands only in the following cycle
	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		@(posedge mclk_i);
		rd_i   <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 check(name, rdata_o & m, exp);
	endtask
	// Let n edges pass and settle
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	// Cycles an on-time window lasts, rounded up to whole clocks
	function automatic int on_cycles(input int ns);
		return (ns + BMFC_CLK_NS - 1) / BMFC_CLK_NS;
	endfunction
	// Trim image with the default mode kept at its reset code
	function automatic logic [31:0] trim_word(input logic [1:0] mn, pf, ss, il, sl, g, input logic [2:0] rc);
		return (32'(mn) << BMFC_MINTON_LSB) | (32'(pf) << BMFC_PFMTON_LSB) | (32'(ss) << BMFC_SS_LSB)
			| (32'(il) << BMFC_ILIM_LSB) | (32'(sl) << BMFC_SLOPE_LSB) | (32'(g) << BMFC_GM_LSB)
			| (32'(rc) << BMFC_RCOMP_LSB) | (32'(BMFC_DEFMODE_RST) << BMFC_DEFMODE_LSB);
	endfunction
	// Verdict and end of run
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Watchdog sized well above the roughly 750 cycles the sequence needs
	initial begin
		repeat (20000) @(posedge mclk_i);
		mismatches++;
		wrap_up();
	end
	// Main sequence
	initial begin
		int hs, pf, n;
		logic [1:0] ss, il, sl, g, mk;
		logic [2:0] rc;
		logic [3:0] rt;
		logic [7:0] r;
		logic uv, ov;
		repeat (2) @(posedge mclk_i);
		reset_i <= 1'b0;
		rd_chk("trim reset", BMFC_OTP_ADDR, 32'h1ffff, trim_word(BMFC_MINTON_RST, BMFC_PFMTON_RST, BMFC_SS_RST,
			BMFC_ILIM_RST, BMFC_SLOPE_RST, BMFC_GM_RST, BMFC_RCOMP_RST));
		rd_chk("mode reset", BMFC_MODE_ADDR, 32'h7, {29'h0, BMFC_PINSEL_RST, BMFC_DEFMODE_RST});
		rd_chk("route reset", BMFC_ROUTE_ADDR, 32'hf, 32'(BMFC_ROUTE_RST));
		rd_chk("mask reset", BMFC_MASK_ADDR, 32'h3, 32'h0);
		rd_chk("unmapped read", 8'h20, 32'hffffffff, 32'h0);
		check("default mode", 32'(pwm), 32'h1);
		// Register mode field with the pin as sync input
		for (int i = 0; i < 2; i++) begin
			wr(BMFC_MODE_ADDR, 32'(i ? BMFC_MODE_PWM : BMFC_MODE_PFM));
			cyc(3);
			check("register mode", 32'(pwm), 32'(i));
		end
		// Pin as mode input; the mode field is left alone meanwhile
		wr(BMFC_MODE_ADDR, {29'h0, 1'b1, BMFC_MODE_PWM});
		for (int p = 0; p < 2; p++) begin
			@(posedge mclk_i);
			pin_req <= 1'(p);
			cyc(5);
			check("pin mode", 32'(pwm), 32'(p == 0));
			check("sync held off", 32'(sync), 32'h0);
		end
		wr(BMFC_MODE_ADDR, {30'h0, BMFC_MODE_PWM});
		cyc(3);
		check("sync follows pin", 32'(sync), 32'h1);
		wr(BMFC_MODE_ADDR, {30'h0, BMFC_MODE_PFM});
		// Ratio around the limit, then random
		for (int i = 0; i < 8; i++) begin
			r = (i < 2) ? 8'(6 + i) : 8'($random(seed) & 8'h0f);
			@(posedge mclk_i);
			vin_vout_ratio_i <= r;
			cyc(3);
			check("half frequency", 32'(half), 32'(r > BMFC_RATIO_LIMIT));
		end
		// Every on-time code in both modes; the pulse-frequency window stays shut in PWM
		for (int i = 0; i < 8; i++) begin
			wr(BMFC_MODE_ADDR, 32'((i < 4) ? BMFC_MODE_PFM : BMFC_MODE_PWM));
			wr(BMFC_OTP_ADDR, trim_word(2'(i), 2'(i), 2'h0, 2'h0, 2'h2, 2'h2, 3'h0));
			hs = 0;
			pf = 0;
			@(posedge mclk_i);
			cycle_start_i <= 1'b1;
			@(posedge mclk_i);
			cycle_start_i <= 1'b0;
			repeat (40) begin
				cyc(1);
				if (hs_on === 1'b1) hs++;
				if (pfm_on === 1'b1) pf++;
			end
			check("min on-time", 32'(hs), 32'(on_cycles(BMFC_MINTON_NS[i % 4])));
			check("pfm on-time", 32'(pf), 32'((i < 4) ? on_cycles(BMFC_PFMTON_NS[i % 4]) : 0));
		end
		// Random compensation, current limit and soft-start selections
		for (int i = 0; i < 4; i++) begin
			{ss, il, sl, g, rc} = 11'($random(seed));
			wr(BMFC_OTP_ADDR, trim_word(2'h1, 2'h2, ss, il, sl, g, rc)); // Recommended on-times
			cyc(3);
			check("slope select", 32'(slope), 32'(sl));
			check("gm select", 32'(gm), 32'(g));
			check("resistor select", 32'(rcomp), 32'(rc));
			check("limit select", 32'(ilim), 32'(il));
		end
		@(posedge mclk_i);
		enable_i <= 1'b1;
		n = 0;
		repeat (40) begin
			cyc(1);
			if (busy === 1'b1) n++;
		end
		check("soft-start length", 32'(n), 32'((int'(ss) + 1) * SS_BASE));
		rd_chk("soft-start done", BMFC_STAT_ADDR, 32'h80, 32'h80);
		@(posedge mclk_i);
		overcurrent_i <= 1'b1;
		cyc(3);
		check("gate blocked", 32'(gate), 32'h0);
		@(posedge mclk_i);
		overcurrent_i <= 1'b0;
		cyc(3);
		check("gate recovered", 32'(gate), 32'h1);
		// Dropping enable returns the sequencer to idle
		@(posedge mclk_i);
		enable_i <= 1'b0;
		cyc(3);
		check("gate idle", 32'(gate), 32'h0);
		// Faults with random routing and mask
		for (int i = 0; i < 8; i++) begin
			uv = (i == 0) | 1'($random(seed));
			ov = (i == 0) | 1'($random(seed));
			rt = 4'($random(seed));
			mk = 2'($random(seed));
			wr(BMFC_ROUTE_ADDR, 32'(rt));
			wr(BMFC_MASK_ADDR, 32'(mk));
			@(posedge mclk_i);
			uv_req <= uv;
			ov_req <= ov;
			cyc(5);
			check("power good 1", 32'(pg1), 32'((ov & rt[0]) | (uv & rt[2])));
			check("power good 2", 32'(pg2), 32'((ov & rt[1]) | (uv & rt[3])));
			rd_chk("live status", BMFC_STAT_ADDR, 32'h3, {30'h0, ov, uv});
			check("irq level", 32'(irq), 32'(|({ov, uv} & mk)));
			@(posedge mclk_i);
			uv_req <= 1'b0;
			ov_req <= 1'b0;
			cyc(4);
			rd_chk("live cleared", BMFC_STAT_ADDR, 32'h3, 32'h0);
			wr(BMFC_FLAG_ADDR, 32'h0);
			rd_chk("flag kept", BMFC_FLAG_ADDR, 32'h3, {30'h0, ov, uv});
			wr(BMFC_FLAG_ADDR, 32'h3);
			rd_chk("flag cleared", BMFC_FLAG_ADDR, 32'h3, 32'h0);
			check("irq cleared", 32'(irq), 32'h0);
		end
		// Clear while both faults stand
		@(posedge mclk_i);
		uv_req <= 1'b1;
		ov_req <= 1'b1;
		cyc(5);
		wr(BMFC_FLAG_ADDR, 32'h3);
		rd_chk("flag survives clear", BMFC_FLAG_ADDR, 32'h3, 32'h3);
		wrap_up();
	end
endmodule
`default_nettype wire
